//--- hdl/fcmon_pkg.sv
// constants, types and carriers for the configuration monitor
package fcmon_pkg;

	// ==============================================
	// timing
	localparam int unsigned CLK_MHZ         = 40;
	localparam int unsigned TICK_NS         = 100;
	localparam int unsigned RELOAD_PULSE_NS = 300;
	localparam int unsigned TICK_CYCLES     = (TICK_NS * CLK_MHZ + 999) / 1000;
	localparam logic [1:0]  RELOAD_TERM     = 2'(RELOAD_PULSE_NS / TICK_NS);
	localparam logic [1:0]  GUARD_ACK_LIMIT = 2'h1;
	localparam logic [1:0]  GUARD_TERM      = 2'h3;

	// ==============================================
	// failure codes and reset values
	localparam logic [2:0] CODE_NONE     = 3'h0;
	localparam logic [2:0] CODE_GUARD    = 3'h1;
	localparam logic [2:0] CODE_CRC      = 3'h2;
	localparam logic [2:0] CODE_SYNC_WORD_CHECK = 3'h4;
	localparam logic [1:0] GOOD_PAGE     = 2'h0;
	localparam logic [1:0] RST_REVISION  = 2'h0;
	localparam logic       RST_EXT_EN    = 1'b0;
	localparam logic       RST_GUARD_EN  = 1'b0;

	// ==============================================
	// register map
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_CTRL   = 8'h04;
	localparam int unsigned CTRL_RELOAD_BIT = 0;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_MONITOR = 2'b01,
		ST_FAIL    = 2'b10,
		ST_PASS    = 2'b11
	} fcmon_state_t;

	// pins from the target and the memory, all asynchronous
	typedef struct packed {
		logic       cfg_ready;
		logic       cfg_done;
		logic       prom_end_of_data_n;
		logic       board_reload_switch;
		logic       target_reload_request;
		logic       guard_timer_clear;
		logic       write_strobe_n;
		logic [1:0] revision_select_in;
		logic       external_revision_enable_in;
		logic       guard_timer_enable_in;
	} fcmon_in_t;

	typedef struct packed {
		logic       fpga_reload_n;
		logic [1:0] revision_select;
		logic       external_revision_enable;
		logic [1:0] guard_timer_count;
		logic [2:0] status_history;
	} fcmon_out_t;

endpackage : fcmon_pkg

//--- hdl/fcmon_top.sv
// configuration monitor: supervisor, reload pulse, revision, history, guard timer
// How it works
// - switch, target command or software request form one internal reload reset.
// - supervisor starts idle and returns idle on any reload request.
// - idle goes to monitoring when the ready line rises.
// - monitoring goes to fail if ready falls before complete is high.
// - monitoring goes to pass when complete rises with ready and end-of-data high.
// - fail drives reload low for 13 clocks (three 100 ns ticks plus one clock), then returns to monitoring.
// - entering fail forces revision select to page 0,0.
// - pass with guard timer disabled returns to idle.
// - pass holds while the target keeps clearing the guard timer.
// - no clear before guard count 01h means fail and known-good reload.
// - guard count rises to 03h, shown on pins; reaching it means fail.
// - reload pulse timed by a two-bit 100 ns counter, terminal 03h.
// - a reload request sets a flag holding reload low until terminal count.
// - idle without the flag keeps the reload line high.
// - external revision select output drives the memory.
// - revision, external select, guard enable load only with write strobe low.
// - three-bit failure history on pins, 000 meaning no failure.
// - guard timeout records code 001.
// - each failure ORs its code into history; reload request clears it.
// - ready falling records code 010 and reloads known-good page.
// - end-of-data falling before ready fell or complete rose records 100.
// - guard timer enable is cleared after reset.
// - one free-running configuration clock runs all logic.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps

module fcmon_top
#(
	parameter int unsigned CLK_MHZ = fcmon_pkg::CLK_MHZ
)
(
	input  wire logic              mclk,
	input  wire logic              rst_b,
	input  wire logic              ce,
	input  wire fcmon_pkg::fcmon_in_t  pins_in,
	output fcmon_pkg::fcmon_out_t      pins_out,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr
);
	import fcmon_pkg::*;

	localparam int unsigned TICKS = (TICK_NS * CLK_MHZ + 999) / 1000;

	if (TICKS < 1 || TICKS > 255)
	begin : g_bad_clock
		$error("fcmon_top: clock rate gives no usable 100 ns tick");
	end

	// ==============================================
	// reset release and pin synchronisers
	logic       rst_meta_ff;
	logic       rst_sync_b;
	fcmon_in_t  sync1_ff;
	fcmon_in_t  sync2_ff;
	fcmon_in_t  prev_ff;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta_ff <= 1'b0;
			rst_sync_b  <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_sync_b  <= rst_meta_ff;
		end
	end

	// idle levels of the pins: strobe high, end-of-data high
	always_ff @(posedge mclk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			sync1_ff <= fcmon_in_t'(11'h110);
			sync2_ff <= fcmon_in_t'(11'h110);
			prev_ff  <= fcmon_in_t'(11'h110);
		end
		else if (ce)
		begin
			sync1_ff <= pins_in;
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff;
		end
	end

	logic ready_rise;
	logic ready_fall;
	logic done_rise;
	logic eod_fall;
	logic reload_req;
	logic apb_reload_ff;

	assign ready_rise = sync2_ff.cfg_ready & ~prev_ff.cfg_ready;
	assign ready_fall = ~sync2_ff.cfg_ready & prev_ff.cfg_ready;
	assign done_rise  = sync2_ff.cfg_done & ~prev_ff.cfg_done;
	assign eod_fall   = ~sync2_ff.prom_end_of_data_n & prev_ff.prom_end_of_data_n;
	assign reload_req = sync2_ff.board_reload_switch
		| sync2_ff.target_reload_request | apb_reload_ff;

	// ==============================================
	// 100 ns tick; restarted with each reload pulse so the pulse is exact
	logic [7:0] div_ff;
	logic       tick;
	logic       pulse_start;

	assign tick = (div_ff == 8'(TICKS - 1));

	always_ff @(posedge mclk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			div_ff <= 8'h00;
		else if (ce)
		begin
			if (pulse_start || tick)
				div_ff <= 8'h00;
			else
				div_ff <= div_ff + 8'h01;
		end
	end

	// ==============================================
	// supervisor
	fcmon_state_t state_ff;
	fcmon_state_t nxt_state;
	logic [2:0]   fail_code;
	logic         enter_fail;
	logic [1:0]   pulse_cnt_ff;
	logic [1:0]   guard_cnt_ff;
	logic         guard_acked_ff;
	logic         guard_en_ff;
	logic         reload_flag_ff;

	always_comb
	begin
		nxt_state = state_ff;
		fail_code = CODE_NONE;
		case (state_ff)
			ST_IDLE:
				if (ready_rise)
					nxt_state = ST_MONITOR;
			ST_MONITOR:
				if (ready_fall && !sync2_ff.cfg_done)
				begin
					nxt_state = ST_FAIL;
					fail_code = CODE_CRC;
				end
				else if (done_rise && sync2_ff.cfg_ready && sync2_ff.prom_end_of_data_n)
					nxt_state = ST_PASS;
				else if (eod_fall && !sync2_ff.cfg_done && sync2_ff.cfg_ready)
				begin
					nxt_state = ST_FAIL;
					fail_code = CODE_SYNC_WORD_CHECK;
				end
			ST_FAIL:
				if (pulse_cnt_ff == RELOAD_TERM)
					nxt_state = ST_MONITOR;
			ST_PASS:
				if (!guard_en_ff)
					nxt_state = ST_IDLE;
				else if (!sync2_ff.guard_timer_clear
					&& ((!guard_acked_ff && guard_cnt_ff == GUARD_ACK_LIMIT)
					|| guard_cnt_ff == GUARD_TERM))
				begin
					nxt_state = ST_FAIL;
					fail_code = CODE_GUARD;
				end
			default:
				nxt_state = ST_IDLE;
		endcase
		if (reload_req)
		begin
			nxt_state = ST_IDLE;
			fail_code = CODE_NONE;
		end
	end

	assign enter_fail  = (nxt_state == ST_FAIL) && (state_ff != ST_FAIL);
	assign pulse_start = enter_fail | reload_req;

	always_ff @(posedge mclk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			state_ff <= ST_IDLE;
		else if (ce)
			state_ff <= nxt_state;
	end

	// ==============================================
	// reload pulse
	logic nxt_reload_flag;
	logic fpga_reload_n_ff;

	always_comb
	begin
		nxt_reload_flag = reload_flag_ff;
		if (reload_req)
			nxt_reload_flag = 1'b1;
		else if (pulse_cnt_ff == RELOAD_TERM)
			nxt_reload_flag = 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			pulse_cnt_ff     <= RELOAD_TERM;
			reload_flag_ff   <= 1'b0;
			fpga_reload_n_ff <= 1'b1;
		end
		else if (ce)
		begin
			if (pulse_start)
				pulse_cnt_ff <= 2'h0;
			else if (tick && pulse_cnt_ff != RELOAD_TERM)
				pulse_cnt_ff <= pulse_cnt_ff + 2'h1;
			reload_flag_ff   <= nxt_reload_flag;
			// aligned with the state register; low in fail or while flagged
			fpga_reload_n_ff <= !((nxt_state == ST_FAIL) || nxt_reload_flag);
		end
	end

	// ==============================================
	// guard timer, runs only in pass
	always_ff @(posedge mclk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			guard_cnt_ff   <= 2'h0;
			guard_acked_ff <= 1'b0;
		end
		else if (ce)
		begin
			if (state_ff != ST_PASS || !guard_en_ff)
			begin
				guard_cnt_ff   <= 2'h0;
				guard_acked_ff <= 1'b0;
			end
			else if (sync2_ff.guard_timer_clear)
			begin
				guard_cnt_ff   <= 2'h0;
				guard_acked_ff <= 1'b1;
			end
			else if (tick && guard_cnt_ff != GUARD_TERM)
				guard_cnt_ff <= guard_cnt_ff + 2'h1;
		end
	end

	// ==============================================
	// target-written revision and enable registers
	logic [1:0] revision_ff;
	logic       ext_en_ff;

	always_ff @(posedge mclk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			revision_ff <= RST_REVISION;
			ext_en_ff   <= RST_EXT_EN;
			guard_en_ff <= RST_GUARD_EN;
		end
		else if (ce)
		begin
			if (!sync2_ff.write_strobe_n)
			begin
				revision_ff <= sync2_ff.revision_select_in;
				ext_en_ff   <= sync2_ff.external_revision_enable_in;
				guard_en_ff <= sync2_ff.guard_timer_enable_in;
			end
			// a failure must win so the retry uses the known-good page
			if (enter_fail)
				revision_ff <= GOOD_PAGE;
		end
	end

	// ==============================================
	// failure history
	logic [2:0] history_ff;

	always_ff @(posedge mclk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			history_ff <= CODE_NONE;
		else if (ce)
		begin
			if (reload_req)
				history_ff <= CODE_NONE;
			else if (enter_fail)
				history_ff <= history_ff | fail_code;
		end
	end

	assign pins_out.fpga_reload_n            = fpga_reload_n_ff;
	assign pins_out.revision_select          = revision_ff;
	assign pins_out.external_revision_enable = ext_en_ff;
	assign pins_out.guard_timer_count        = guard_cnt_ff;
	assign pins_out.status_history           = history_ff;

	// ==============================================
	// apb slave, zero wait states
	logic        setup;
	logic        hit;
	logic [31:0] prdata_ff;
	logic        pslverr_ff;

	assign setup = psel & ~penable;
	assign hit   = (paddr == OFS_STATUS) || (paddr == OFS_CTRL);

	always_ff @(posedge mclk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			prdata_ff     <= 32'h0000_0000;
			pslverr_ff    <= 1'b0;
			apb_reload_ff <= 1'b0;
		end
		else if (ce)
		begin
			apb_reload_ff <= 1'b0;
			if (setup)
			begin
				pslverr_ff <= !hit;
				prdata_ff  <= 32'h0000_0000;
				if (!pwrite && paddr == OFS_STATUS)
					prdata_ff <= {13'h0000, fpga_reload_n_ff, guard_en_ff, ext_en_ff,
						2'h0, revision_ff, 2'h0, guard_cnt_ff, 2'h0, state_ff,
						1'b0, history_ff};
			end
			if (psel && penable && pwrite && paddr == OFS_CTRL)
				apb_reload_ff <= pwdata[CTRL_RELOAD_BIT];
		end
	end

	assign pready  = 1'b1;
	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff & psel & penable;

	// ==============================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_sync_b);

	sequence s_fail_entry;
		ce && enter_fail;
	endsequence

	sequence s_reload_low12;
		(!fpga_reload_n_ff)[*8] ##1 (!fpga_reload_n_ff)[*4];
	endsequence

	a_reload_to_idle: assert property (ce && reload_req |=> state_ff == ST_IDLE)
		else $error("reload request did not return supervisor to idle");
	a_ready_rise_mon: assert property (
		ce && state_ff == ST_IDLE && ready_rise && !reload_req
		|=> state_ff == ST_MONITOR)
		else $error("ready rise in idle did not start monitoring");
	a_crc_fail_code: assert property (
		ce && state_ff == ST_MONITOR && ready_fall && !sync2_ff.cfg_done && !reload_req
		|=> state_ff == ST_FAIL && history_ff[1])
		else $error("ready fall during monitoring not treated as failure");
	a_pass_entry: assert property (
		ce && state_ff == ST_MONITOR && !ready_fall && done_rise && sync2_ff.cfg_ready
		&& sync2_ff.prom_end_of_data_n && !reload_req |=> state_ff == ST_PASS)
		else $error("complete rise did not reach pass");
	a_fail_page_zero: assert property (s_fail_entry |=> revision_ff == GOOD_PAGE)
		else $error("revision not forced to known-good page on failure");
	a_pulse_width: assert property (s_fail_entry |=> s_reload_low12)
		else $error("reload pulse shorter than 300 ns");
	a_idle_high: assert property (
		state_ff == ST_IDLE && !reload_flag_ff |-> fpga_reload_n_ff)
		else $error("reload driven low in idle without request");
	a_history_or: assert property (
		s_fail_entry and (!reload_req)
		|=> history_ff == ($past(history_ff) | $past(fail_code)))
		else $error("history not ORed with failure code");
	a_guard_timeout: assert property (
		ce && state_ff == ST_PASS && guard_en_ff && guard_cnt_ff == GUARD_ACK_LIMIT
		&& !guard_acked_ff && !sync2_ff.guard_timer_clear && !reload_req
		|=> state_ff == ST_FAIL && history_ff[0])
		else $error("unacknowledged guard timer did not fail");
	a_strobe_load: assert property (
		ce && sync2_ff.write_strobe_n |=> $stable(guard_en_ff) && $stable(ext_en_ff))
		else $error("enable registers changed without write strobe");
	a_flag_holds: assert property (
		ce && reload_req |=> !fpga_reload_n_ff && reload_flag_ff)
		else $error("reload request did not set flag and drive reload low");

endmodule : fcmon_top

//--- sim/fcm_partner.sv
// behavioural memory and target: one configuration attempt after each reload
`timescale 1ns/1ps

module fcm_partner
(
	input  wire logic       mclk,
	input  wire logic       reload_n,
	input  wire logic       start,
	input  wire logic [1:0] mode,
	output logic            ready = 1'b0,
	output logic            done = 1'b0,
	output logic            eod_n = 1'b1,
	output logic            busy = 1'b0
);
	int cnt = 0;

	// ==============================================
	// attempt sequencer; mode 0 good, 1 checksum error, 2 missing sync word
	always @(posedge mclk)
	begin
		if (!reload_n || start)
		begin
			ready <= 1'b0;
			done <= 1'b0;
			eod_n <= 1'b1;
			busy <= 1'b1;
			cnt <= 0;
		end
		else if (busy)
		begin
			cnt <= cnt + 1;
			if (cnt == 4)
				ready <= 1'b1;
			if (cnt == 14)
			begin
				busy <= 1'b0;
				case (mode)
					2'h0: done <= 1'b1;
					2'h1: ready <= 1'b0;
					default: eod_n <= 1'b0;
				endcase
			end
		end
	end

endmodule : fcm_partner

//--- sim/tb_top.sv
// self-checking bench for the configuration monitor
`timescale 1ns/1ps

module tb_top;
	import fcmon_pkg::*;

	typedef struct packed
	{
		logic [31:0] d;
		logic [31:0] m;
		logic        e;
	} fcm_exp_t;

	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	fcmon_in_t   pins_in;
	fcmon_out_t  pins_out;
	logic        sw = 1'b0, req = 1'b0, clr = 1'b0, wr_n = 1'b1, start = 1'b0;
	logic        ext_in = 1'b0, gen_in = 1'b0;
	logic        ce = 1'b1;
	logic [1:0]  rev_in = 2'h0, mode = 2'h0, r;
	logic        ready, done, eod_n, busy;
	logic [31:0] seed = 32'h0ad4;
	int          mismatches = 0, n_tests = 0, cyc = 0, d, w;
	fcm_exp_t    q[$];
	fcm_exp_t    ex;

	assign pins_in = {ready, done, eod_n, sw, req, clr, wr_n, rev_in, ext_in, gen_in};

	always #12.5 mclk = ~mclk;

	fcmon_top uut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .pins_in(pins_in),
		.pins_out(pins_out), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr));

	fcm_partner model (.mclk(mclk), .reload_n(pins_out.fpga_reload_n), .start(start),
		.mode(mode), .ready(ready), .done(done), .eod_n(eod_n), .busy(busy));

	// ==============================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	function automatic logic [31:0] st(input logic [2:0] h, input logic [1:0] s,
		input logic [1:0] c, input logic [1:0] rv, input logic x, input logic g,
		input logic l);
		return {13'h0, l, g, x, 2'h0, rv, 2'h0, c, 2'h0, s, 1'b0, h};
	endfunction : st

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			mismatches++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask : chk

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask : tick

	// master holds the whole request until pready is seen high at an edge
	task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] dv);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= dv;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic er);
		q.push_back('{d: e, m: m, e: er});
		apb(a, 1'b0, 32'h0);
	endtask : rd

	task automatic strobe;
		@(posedge mclk);
		wr_n <= 1'b0;
		repeat (2) @(posedge mclk);
		wr_n <= 1'b1;
	endtask : strobe

	task automatic go(input logic [1:0] m);
		@(posedge mclk);
		mode <= m;
		start <= 1'b1;
		@(posedge mclk);
		start <= 1'b0;
	endtask : go

	// settle allowance covers the input synchronisers and one state step
	task automatic wait_idle;
		int k;
		k = 0;
		tick(1);
		while (busy !== 1'b0 && k < 400)
		begin
			tick(1);
			k++;
		end
		tick(8);
	endtask : wait_idle

	// d: cycles until the reload line falls, w: cycles it stays low
	task automatic pulse(input logic fail);
		d = 0;
		w = 0;
		tick(1);
		while (pins_out.fpga_reload_n === 1'b1 && d < 200)
		begin
			tick(1);
			d++;
		end
		mode <= 2'h0;
		while (pins_out.fpga_reload_n === 1'b0 && w < 200)
		begin
			if (fail && w == 1)
				chk(32'(pins_out.revision_select), 32'(GOOD_PAGE));
			tick(1);
			w++;
		end
	endtask : pulse

	// ==============================================
	// read data checker: oldest note against each completed read
	always @(posedge mclk)
	begin
		if (psel && penable && pready && !pwrite && q.size() > 0)
		begin
			ex = q.pop_front();
			chk(prdata & ex.m, ex.d & ex.m);
			chk(32'(pslverr), 32'(ex.e));
		end
	end

	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			give_verdict();
		end
	end

	// ==============================================
	// main sequence
	initial
	begin
		seed = xs(seed);
		r = (seed[1:0] == 2'h0) ? 2'h1 : seed[1:0];
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		tick(4);
		chk(32'(pins_out), 32'h100);
		rd(OFS_STATUS, '1, st(3'h0, ST_IDLE, 2'h0, 2'h0, 1'b0, 1'b0, 1'b1), 1'b0);
		rd(8'h08, '1, 32'h0, 1'b1);
		$display("test 1 done");
		@(posedge mclk);
		rev_in <= r;
		ext_in <= 1'b1;
		tick(8);
		chk(32'(pins_out.revision_select), 32'h0);
		strobe();
		tick(8);
		chk(32'(pins_out.revision_select), 32'(r));
		chk(32'(pins_out.external_revision_enable), 32'h1);
		$display("test 2 done");
		go(2'h0);
		wait_idle();
		rd(OFS_STATUS, '1, st(3'h0, ST_IDLE, 2'h0, r, 1'b1, 1'b0, 1'b1), 1'b0);
		$display("test 3 done");
		go(2'h1);
		pulse(1'b1);
		chk(32'(w), 32'd13);
		wait_idle();
		rd(OFS_STATUS, '1, st(3'h2, ST_IDLE, 2'h0, 2'h0, 1'b1, 1'b0, 1'b1), 1'b0);
		go(2'h2);
		pulse(1'b1);
		chk(32'(w), 32'd13);
		wait_idle();
		rd(OFS_STATUS, '1, st(3'h6, ST_IDLE, 2'h0, 2'h0, 1'b1, 1'b0, 1'b1), 1'b0);
		$display("test 4 done");
		for (int i = 0; i < 3; i++)
		begin
			if (i == 2)
				apb(OFS_CTRL, 1'b1, 32'h1);
			else
			begin
				@(posedge mclk);
				sw <= (i == 0);
				req <= (i == 1);
				repeat (3) @(posedge mclk);
				sw <= 1'b0;
				req <= 1'b0;
			end
			pulse(1'b0);
			chk(32'(w >= 12), 32'h1);
			wait_idle();
			rd(OFS_STATUS, 32'h40037, st(3'h0, ST_IDLE, 2'h0, 2'h0, 1'b0, 1'b0, 1'b1), 1'b0);
		end
		$display("test 5 done");
		@(posedge mclk);
		gen_in <= 1'b1;
		clr <= 1'b1;
		strobe();
		go(2'h0);
		wait_idle();
		tick(40);
		rd(OFS_STATUS, 32'h20330, st(3'h0, ST_PASS, 2'h0, 2'h0, 1'b0, 1'b1, 1'b0), 1'b0);
		@(posedge mclk);
		clr <= 1'b0;
		pulse(1'b1);
		chk(32'(w), 32'd13);
		pulse(1'b1);
		chk(32'(d >= 18 && d <= 28), 32'h1);
		@(posedge mclk);
		gen_in <= 1'b0;
		strobe();
		wait_idle();
		rd(OFS_STATUS, 32'h20037, st(3'h1, ST_IDLE, 2'h0, 2'h0, 1'b0, 1'b0, 1'b1), 1'b0);
		$display("test 6 done");
		// clock enable low must hide a switch press entirely
		@(posedge mclk);
		ce <= 1'b0;
		sw <= 1'b1;
		repeat (6) @(posedge mclk);
		sw <= 1'b0;
		ce <= 1'b1;
		tick(8);
		chk(32'(pins_out.fpga_reload_n), 32'h1);
		chk(32'(pins_out.status_history), 32'(CODE_GUARD));
		$display("test 7 done");
		tick(4);
		give_verdict();
	end

endmodule : tb_top
